// ### rtl/gpio_scan_regs.sv
// Register bank for general-purpose outputs, input readback and channel scan control.
`timescale 1ns/1ns
module gpio_scan_regs
    import gpio_seq_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // Register access port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_rvalid_o,
    // Pin configuration held elsewhere
    input  wire logic [7:0] pin_is_gpio_i,
    input  wire logic [7:0] gpio_is_output_i,
    // Channel pins
    input  wire logic [7:0] pin_in_i,
    output logic      [7:0] pin_out_o,
    output logic      [7:0] pin_oe_n_o,
    // Conversion engine side
    input  wire logic       conv_done_i,
    input  wire logic [3:0] otf_chid_i,
    output logic      [2:0] conv_channel_o,
    output logic            conv_channel_valid_o,
    output logic            scan_running_o,
    output logic      [7:0] alert_channel_mask_o
);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [7:0] drive_type_q, drive_type_d;
    logic [7:0] out_level_q,  out_level_d;
    logic [7:0] in_level_q,   in_level_d;
    logic       scan_go_q,    scan_go_d;
    logic [1:0] scan_mode_q,  scan_mode_d;
    logic [3:0] chid_q,       chid_d;
    logic [7:0] scan_mask_q,  scan_mask_d;
    logic [7:0] alert_mask_q, alert_mask_d;

    always_comb begin
        drive_type_d = drive_type_q;
        out_level_d  = out_level_q;
        scan_go_d    = scan_go_q;
        scan_mode_d  = scan_mode_q;
        chid_d       = chid_q;
        scan_mask_d  = scan_mask_q;
        alert_mask_d = alert_mask_q;
        in_level_d   = pin_in_i;
        if (reg_wr_i) begin
            if (reg_addr_i == OFS_OUTPUT_DRIVE_TYPE) begin
                drive_type_d = reg_wdata_i;
            end else if (reg_addr_i == OFS_OUTPUT_LEVEL) begin
                out_level_d = reg_wdata_i;
            end else if (reg_addr_i == OFS_SCAN_CONFIG) begin
                scan_go_d   = reg_wdata_i[POS_SCAN_GO];
                scan_mode_d = reg_wdata_i[POS_SCAN_MODE_HI:POS_SCAN_MODE_LO];
            end else if (reg_addr_i == OFS_MANUAL_CHANNEL_SEL) begin
                chid_d = reg_wdata_i[POS_CHID_HI:0];
            end else if (reg_addr_i == OFS_SCAN_ENABLE_MASK) begin
                scan_mask_d = reg_wdata_i;
            end else if (reg_addr_i == OFS_ALERT_CHANNEL_MASK) begin
                alert_mask_d = reg_wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            drive_type_q <= RST_REG8;
            out_level_q  <= RST_REG8;
            in_level_q   <= RST_REG8;
            scan_go_q    <= 1'b0;
            scan_mode_q  <= RST_MODE;
            chid_q       <= RST_CHID;
            scan_mask_q  <= RST_REG8;
            alert_mask_q <= RST_REG8;
        end else begin
            drive_type_q <= drive_type_d;
            out_level_q  <= out_level_d;
            in_level_q   <= in_level_d;
            scan_go_q    <= scan_go_d;
            scan_mode_q  <= scan_mode_d;
            chid_q       <= chid_d;
            scan_mask_q  <= scan_mask_d;
            alert_mask_q <= alert_mask_d;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;

    always_comb begin
        rdata_d  = 8'h00;
        rvalid_d = reg_rd_i;
        if (reg_rd_i) begin
            if (reg_addr_i == OFS_OUTPUT_DRIVE_TYPE) begin
                rdata_d = drive_type_q;
            end else if (reg_addr_i == OFS_OUTPUT_LEVEL) begin
                rdata_d = out_level_q;
            end else if (reg_addr_i == OFS_INPUT_LEVEL) begin
                rdata_d = in_level_q;
            end else if (reg_addr_i == OFS_SCAN_CONFIG) begin
                rdata_d = {3'h0, scan_go_q, 2'h0, scan_mode_q};
            end else if (reg_addr_i == OFS_MANUAL_CHANNEL_SEL) begin
                rdata_d = {4'h0, chid_q};
            end else if (reg_addr_i == OFS_SCAN_ENABLE_MASK) begin
                rdata_d = scan_mask_q;
            end else if (reg_addr_i == OFS_ALERT_CHANNEL_MASK) begin
                rdata_d = alert_mask_q;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Open-drain outputs only ever pull low; the high level comes from the board pull-up.
    logic [7:0] pin_out_q, pin_out_d;
    logic [7:0] pin_oe_n_q, pin_oe_n_d;
    logic [7:0] drive_en;

    always_comb begin
        drive_en   = pin_is_gpio_i & gpio_is_output_i;
        pin_out_d  = 8'h00;
        pin_oe_n_d = 8'hff;
        for (int i = 0; i < 8; i++) begin
            if (drive_en[i]) begin
                pin_out_d[i] = out_level_q[i];
                if (drive_type_q[i]) begin
                    pin_oe_n_d[i] = 1'b0;
                end else begin
                    pin_oe_n_d[i] = out_level_q[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_out_q  <= 8'h00;
            pin_oe_n_q <= 8'hff;
        end else begin
            pin_out_q  <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // ************************************************************
    // Scan sequencer
    // ************************************************************
    scan_if scan_bus ();

    assign scan_bus.mode      = scan_mode_q;
    assign scan_bus.go        = scan_go_q;
    assign scan_bus.mask      = scan_mask_q;
    assign scan_bus.manual_id = chid_q;
    assign scan_bus.otf_id    = otf_chid_i;
    assign scan_bus.conv_done = conv_done_i;

    scan_sequencer u_seq (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .bus        (scan_bus.seq)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata_o          = rdata_q;
    assign reg_rvalid_o         = rvalid_q;
    assign pin_out_o            = pin_out_q;
    assign pin_oe_n_o           = pin_oe_n_q;
    assign conv_channel_o       = scan_bus.chan;
    assign conv_channel_valid_o = scan_bus.chan_valid;
    assign scan_running_o       = scan_bus.running;
    assign alert_channel_mask_o = alert_mask_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    AST_PUSH_PULL: assert property (
        (pin_is_gpio_i[0] && gpio_is_output_i[0] && drive_type_q[0])
        |=> !pin_oe_n_o[0] && pin_out_o[0] == $past(out_level_q[0]))
        else $error("Push-pull channel 0 not actively driven.");
    AST_OPEN_DRAIN: assert property (
        (pin_is_gpio_i[1] && gpio_is_output_i[1] && !drive_type_q[1])
        |=> pin_oe_n_o[1] == $past(out_level_q[1]))
        else $error("Open-drain channel 1 drove a high level.");
    AST_LEVEL_WRITE: assert property (
        (reg_wr_i && reg_addr_i == OFS_OUTPUT_LEVEL)
        |-> ##2 pin_out_o
            == ($past(reg_wdata_i, 2) & $past(pin_is_gpio_i & gpio_is_output_i)))
        else $error("Written output level did not reach the pins.");
    AST_INPUT_READ: assert property (
        reg_rd_i && reg_addr_i == OFS_INPUT_LEVEL ##0 !$past(reset_i)
        |=> reg_rvalid_o && reg_rdata_o == $past(pin_in_i, 2))
        else $error("Input level readback does not match the pins.");
    AST_RESERVED_ZERO: assert property (
        reg_rd_i && (reg_addr_i == OFS_SCAN_CONFIG || reg_addr_i == OFS_MANUAL_CHANNEL_SEL)
        |=> (($past(reg_addr_i) == OFS_SCAN_CONFIG) ? (reg_rdata_o & 8'hec) == 8'h00
             : reg_rdata_o[7:4] == 4'h0))
        else $error("Reserved bits did not read as zero.");
    AST_NOT_OUTPUT: assert property (
        (!pin_is_gpio_i[2] || !gpio_is_output_i[2]) |=> pin_oe_n_o[2] && !pin_out_o[2])
        else $error("Channel 2 drove a pin while not a digital output.");

    AST_RESET_ZERO: assert property (@(posedge core_clk_i)
        $past(reset_i) |-> drive_type_q == 8'h00 && out_level_q == 8'h00
            && scan_mask_q == 8'h00 && alert_mask_q == 8'h00 && chid_q == 4'h0
            && scan_mode_q == 2'h0 && !scan_go_q)
        else $error("Register not zero after reset.");

    // ************************************************************
    // Checks on stored values, readback and pin safety
    // ************************************************************
    AST_DRIVE_STORE: assert property (
        (reg_wr_i && reg_addr_i == OFS_OUTPUT_DRIVE_TYPE)
        |=> drive_type_q == $past(reg_wdata_i))
        else $error("Drive type write did not land.");

    AST_LEVEL_STORE: assert property (
        (reg_wr_i && reg_addr_i == OFS_OUTPUT_LEVEL)
        |=> out_level_q == $past(reg_wdata_i))
        else $error("Output level write did not land.");

    AST_MODE_STORE: assert property (
        (reg_wr_i && reg_addr_i == OFS_SCAN_CONFIG)
        |=> scan_mode_q == $past(reg_wdata_i[POS_SCAN_MODE_HI:POS_SCAN_MODE_LO])
            && scan_go_q == $past(reg_wdata_i[POS_SCAN_GO]))
        else $error("Scan configuration write did not land.");

    AST_CHID_STORE: assert property (
        (reg_wr_i && reg_addr_i == OFS_MANUAL_CHANNEL_SEL)
        |=> chid_q == $past(reg_wdata_i[POS_CHID_HI:0]))
        else $error("Channel identifier write did not land.");

    AST_MASK_STORE: assert property (
        (reg_wr_i && reg_addr_i == OFS_SCAN_ENABLE_MASK)
        |=> scan_mask_q == $past(reg_wdata_i))
        else $error("Scan enable mask write did not land.");

    AST_CONFIG_HOLD: assert property (
        !reg_wr_i |=> $stable(drive_type_q) && $stable(out_level_q) && $stable(scan_mask_q))
        else $error("A setting changed without a write.");

    AST_INPUT_TRACK: assert property (
        1'b1 |=> in_level_q == $past(pin_in_i))
        else $error("Input level register did not follow the pins.");

    AST_READ_DRIVE: assert property (
        (reg_rd_i && reg_addr_i == OFS_OUTPUT_DRIVE_TYPE)
        |=> reg_rvalid_o && reg_rdata_o == $past(drive_type_q))
        else $error("Drive type readback is wrong.");

    AST_READ_LEVEL: assert property (
        (reg_rd_i && reg_addr_i == OFS_OUTPUT_LEVEL)
        |=> reg_rvalid_o && reg_rdata_o == $past(out_level_q))
        else $error("Output level readback is wrong.");

    AST_READ_MODE: assert property (
        (reg_rd_i && reg_addr_i == OFS_SCAN_CONFIG)
        |=> reg_rdata_o[POS_SCAN_GO] == $past(scan_go_q)
            && reg_rdata_o[POS_SCAN_MODE_HI:POS_SCAN_MODE_LO] == $past(scan_mode_q))
        else $error("Scan configuration readback is wrong.");

    AST_READ_MASK: assert property (
        (reg_rd_i && reg_addr_i == OFS_SCAN_ENABLE_MASK)
        |=> reg_rvalid_o && reg_rdata_o == $past(scan_mask_q))
        else $error("Scan enable mask readback is wrong.");

    AST_OD_NEVER_HIGH: assert property (
        1'b1 |=> (~pin_oe_n_o & pin_out_o & ~$past(drive_type_q)) == 8'h00)
        else $error("An open-drain channel drove a high level.");

    AST_NO_DRIVE_INPUT: assert property (
        1'b1 |=> (~pin_oe_n_o & ~$past(pin_is_gpio_i & gpio_is_output_i)) == 8'h00)
        else $error("A channel drove its pin while not a digital output.");

    AST_PIN_LEVEL: assert property (
        1'b1 |=> pin_out_o == ($past(out_level_q) & $past(pin_is_gpio_i & gpio_is_output_i)))
        else $error("Pin output level does not follow the output level setting.");

endmodule : gpio_scan_regs

// ### rtl/gpio_seq_pkg.sv
// Constants, field layouts and a helper function shared by the GPIO and scan register block.
// Overview of operation
// - Drive-type bit zero makes output open-drain, one makes it push-pull.
// - Output level bit sets the driven level, zero low and one high.
// - Input level register returns the present level of each channel pin.
// - Scan mode 00 manual, 01 automatic, 10 on-the-fly, 11 reserved.
// - Scan go bit starts or stops scanning, only in automatic mode.
// - Automatic scan converts enabled channels in ascending order, skipping disabled ones.
// - In manual mode the channel identifier picks the next sampled input.
// - Identifiers 0 to 7 pick inputs 0 to 7; top bit set is reserved.
// - Scan enable mask bit one includes its input, zero excludes it.
// - Reserved bits of scan config and channel select read back zero.
// - Every register of the group except input level holds zero after reset; input level follows the pins from the next cycle.
// - Pin-function bit one makes the channel general-purpose, zero keeps it analog.
// - Direction bit one makes a general-purpose channel an output, zero an input.
package gpio_seq_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_OUTPUT_DRIVE_TYPE  = 8'h09;
    localparam logic [7:0] OFS_OUTPUT_LEVEL       = 8'h0b;
    localparam logic [7:0] OFS_INPUT_LEVEL        = 8'h0d;
    localparam logic [7:0] OFS_SCAN_CONFIG        = 8'h10;
    localparam logic [7:0] OFS_MANUAL_CHANNEL_SEL = 8'h11;
    localparam logic [7:0] OFS_SCAN_ENABLE_MASK   = 8'h12;
    localparam logic [7:0] OFS_ALERT_CHANNEL_MASK = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         POS_SCAN_GO      = 4;
    localparam int         POS_SCAN_MODE_HI = 1;
    localparam int         POS_SCAN_MODE_LO = 0;
    localparam int         POS_CHID_HI      = 3;
    localparam logic [7:0] RST_REG8         = 8'h00;
    localparam logic [3:0] RST_CHID         = 4'h0;
    localparam logic [1:0] RST_MODE         = 2'h0;

    // ************************************************************
    // Scan modes
    // ************************************************************
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO   = 2'h1;
    localparam logic [1:0] MODE_OTF    = 2'h2;

    // Finds the next enabled channel above cur, wrapping; returns cur if none is enabled.
    function automatic logic [2:0] next_chan(input logic [7:0] mask, input logic [2:0] cur);
        logic [2:0] res;
        logic [2:0] idx;
        logic       found;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            idx = 3'(cur + 3'(i));
            if (!found && mask[idx]) begin
                res   = idx;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_chan

endpackage : gpio_seq_pkg

// ### rtl/scan_if.sv
// Interface carrying scan settings and scan state between the register bank and the sequencer.
`timescale 1ns/1ns
interface scan_if;
    logic [1:0] mode;
    logic       go;
    logic [7:0] mask;
    logic [3:0] manual_id;
    logic [3:0] otf_id;
    logic       conv_done;
    logic [2:0] chan;
    logic       chan_valid;
    logic       running;

    modport regs (output mode, go, mask, manual_id, otf_id, conv_done,
                  input  chan, chan_valid, running);
    modport seq  (input  mode, go, mask, manual_id, otf_id, conv_done,
                  output chan, chan_valid, running);
endinterface : scan_if

// ### rtl/scan_sequencer.sv
// Channel sequencer for manual, automatic and on-the-fly scanning.
`timescale 1ns/1ns
module scan_sequencer
    import gpio_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Scan settings and state
    scan_if.seq      bus
);

    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

    seq_state_t state_q, state_d;
    logic [2:0] chan_q, chan_d;
    logic       valid_q, valid_d;
    logic       auto_on;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        auto_on = (bus.mode == MODE_AUTO) && bus.go;
        state_d = state_q;
        chan_d  = chan_q;
        valid_d = 1'b0;
        case (bus.mode)
            MODE_MANUAL: begin
                state_d = SEQ_IDLE;
                chan_d  = bus.manual_id[2:0];
                valid_d = !bus.manual_id[POS_CHID_HI];
            end
            MODE_OTF: begin
                state_d = SEQ_IDLE;
                chan_d  = bus.otf_id[2:0];
                valid_d = !bus.otf_id[POS_CHID_HI];
            end
            MODE_AUTO: begin
                case (state_q)
                    SEQ_IDLE: begin
                        if (auto_on) begin
                            state_d = SEQ_RUN;
                            chan_d  = next_chan(bus.mask, 3'h7);
                        end
                    end
                    default: begin
                        if (!auto_on) begin
                            state_d = SEQ_IDLE;
                        end else if (bus.conv_done) begin
                            chan_d = next_chan(bus.mask, chan_q);
                        end
                    end
                endcase
                valid_d = auto_on && bus.mask[chan_d];
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= SEQ_IDLE;
            chan_q  <= 3'h0;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            chan_q  <= chan_d;
            valid_q <= valid_d;
        end
    end

    assign bus.chan       = chan_q;
    assign bus.chan_valid = valid_q;
    assign bus.running    = (state_q == SEQ_RUN);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    AST_SCAN_ASCENDING: assert property (
        (state_q == SEQ_RUN && bus.mode == MODE_AUTO && bus.go && bus.conv_done)
        |=> chan_q == next_chan($past(bus.mask), $past(chan_q)))
        else $error("Automatic scan did not move to the next enabled channel.");
    AST_SCAN_STOP: assert property (
        (bus.mode != MODE_AUTO || !bus.go)
        |=> state_q == SEQ_IDLE && ($past(bus.mode) != MODE_AUTO || !valid_q))
        else $error("Scan kept running without go in automatic mode.");
    AST_SCAN_SKIP: assert property (
        (valid_q && bus.mode == MODE_AUTO && $past(bus.mode) == MODE_AUTO && $stable(bus.mask))
        |-> bus.mask[chan_q])
        else $error("A disabled channel was presented during automatic scan.");
    AST_MANUAL_PICK: assert property (
        (bus.mode == MODE_MANUAL && !bus.manual_id[3])
        |=> valid_q && chan_q == $past(bus.manual_id[2:0]))
        else $error("Manual channel identifier not applied.");
    AST_RESERVED_ID: assert property (
        (bus.mode == MODE_MANUAL && bus.manual_id[3]) |=> !valid_q)
        else $error("Reserved channel identifier produced a valid channel.");

endmodule : scan_sequencer

// ### bench/pin_pad_model.sv
// Board-side pad model that resolves each channel pin from device drive, an external source and pull-ups.
`timescale 1ns/1ns
module pin_pad_model (
    // Device side
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_n_i,
    // External source
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    // Resolved pin level
    output logic      [7:0] pin_level_o
);
    // A pin that nobody drives sits at the board pull-up, so a released open-drain pin reads high.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n_i[i]) begin
                pin_level_o[i] = pin_out_i[i];
            end else if (ext_en_i[i]) begin
                pin_level_o[i] = ext_val_i[i];
            end else begin
                pin_level_o[i] = 1'b1;
            end
        end
    end
endmodule : pin_pad_model

// ### bench/gpio_and_channel_sequence_regs_tb.sv
// Self-checking testbench for the GPIO and channel scan register bank.
`timescale 1ns/1ns
module gpio_and_channel_sequence_regs_tb;
    import gpio_seq_pkg::*;
    logic       core_clk_i, reset_i, reg_wr_i, reg_rd_i, conv_done_i, rvalid, running, valid;
    logic [7:0] addr, wdata, rdata, gpio, dir, pin_lvl, pin_out, pin_oe_n, ext_val, ext_en, alert;
    logic [3:0] otf_id;
    logic [2:0] chan;
    logic [7:0] rd_q;
    int         fails;
    int         compares;

    gpio_scan_regs i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .pin_is_gpio_i(gpio), .gpio_is_output_i(dir),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n),
        .conv_done_i(conv_done_i), .otf_chid_i(otf_id), .conv_channel_o(chan),
        .conv_channel_valid_o(valid), .scan_running_o(running), .alert_channel_mask_o(alert));

    pin_pad_model i_pad (.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pin_level_o(pin_lvl));

    // ************************************************************
    // Common tasks
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        addr     <= a;
        wdata    <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // The read answer stands for one cycle only, so it is captured right after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        addr     <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({7'h0, rvalid}, 8'h01);
        d = rdata;
    endtask : rd

    task automatic pulse_done();
        @(posedge core_clk_i);
        conv_done_i <= 1'b1;
        @(posedge core_clk_i);
        conv_done_i <= 1'b0;
        settle(1);
    endtask : pulse_done

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        logic [7:0] ofs [7] = '{8'h09, 8'h0b, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h14};
        ext_en <= 8'hff;
        ext_val <= 8'h00;
        foreach (ofs[i]) begin
            rd(ofs[i], rd_q);
            chk(rd_q, 8'h00);
        end
        chk(pin_oe_n, 8'hff);
        chk(pin_out, 8'h00);
    endtask : t_reset

    task automatic t_regs();
        logic [7:0] ofs [4] = '{8'h09, 8'h0b, 8'h12, 8'h14};
        @(posedge core_clk_i);
        ext_val <= 8'h3c;
        foreach (ofs[i]) begin
            wr(ofs[i], 8'ha5);
            rd(ofs[i], rd_q);
            chk(rd_q, 8'ha5);
        end
        chk(alert, 8'ha5);
        wr(8'h10, 8'hff);
        rd(8'h10, rd_q);
        chk(rd_q, 8'h13);
        settle(2);
        chk({7'h0, valid}, 8'h00);
        wr(8'h11, 8'hff);
        rd(8'h11, rd_q);
        chk(rd_q, 8'h0f);
        wr(8'h0d, 8'hff);
        rd(8'h0d, rd_q);
        chk(rd_q, 8'h3c);
        rd(8'h0a, rd_q);
        chk(rd_q, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h00);
    endtask : t_regs

    task automatic t_pins();
        logic [7:0] lvl [2] = '{8'h0a, 8'h05};
        logic [7:0] isout;
        @(posedge core_clk_i);
        gpio    <= 8'hff;
        dir     <= 8'h0f;
        ext_en  <= 8'hf0;
        ext_val <= 8'ha0;
        wr(8'h09, 8'h05);
        isout = 8'h0f;
        foreach (lvl[i]) begin
            wr(8'h0b, lvl[i]);
            settle(3);
            chk(pin_out, lvl[i] & isout);
            chk(pin_oe_n, ~isout | (~8'h05 & lvl[i]));
            rd(8'h0d, rd_q);
            chk(rd_q, 8'ha0 | lvl[i]);
        end
        @(posedge core_clk_i);
        dir <= 8'h00;
        settle(3);
        chk(pin_oe_n, 8'hff);
        @(posedge core_clk_i);
        dir  <= 8'h0f;
        gpio <= 8'h00;
        settle(3);
        chk(pin_oe_n, 8'hff);
        chk(pin_out, 8'h00);
    endtask : t_pins

    task automatic t_manual();
        for (int id = 0; id < 9; id++) begin
            wr(8'h11, 8'(id));
            settle(2);
            if (id < 8) begin
                chk({5'h0, chan}, 8'(id));
            end
            chk({7'h0, valid}, (id < 8) ? 8'h01 : 8'h00);
        end
    endtask : t_manual

    task automatic t_scan();
        logic [7:0] exp [3] = '{8'h02, 8'h07, 8'h00};
        wr(8'h12, 8'h85);
        wr(8'h10, 8'h11);
        settle(2);
        chk({7'h0, running}, 8'h01);
        chk({5'h0, chan}, 8'h00);
        foreach (exp[i]) begin
            pulse_done();
            chk({5'h0, chan}, exp[i]);
        end
        wr(8'h10, 8'h01);
        settle(2);
        chk({7'h0, running}, 8'h00);
        @(posedge core_clk_i);
        otf_id <= 4'h5;
        wr(8'h10, 8'h12);
        settle(2);
        chk({7'h0, running}, 8'h00);
        chk({4'h0, valid, chan}, 8'h0d);
    endtask : t_scan

    // ************************************************************
    // Clock, reset, sequence and verdict
    // ************************************************************
    task automatic end_sim();
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    initial begin
        #40000;
        fails++;
        end_sim();
    end

    initial begin
        fails = 0;
        compares = 0;
        reset_i = 1'b1;
        {reg_wr_i, reg_rd_i, conv_done_i} = 3'h0;
        {addr, wdata, gpio, dir, ext_val, ext_en} = 48'h0;
        otf_id = 4'h0;
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_regs();
        t_pins();
        t_manual();
        t_scan();
        end_sim();
    end
endmodule : gpio_and_channel_sequence_regs_tb
